// ### hdl/oscc_regs.sv
`timescale 1ns/100ps
`default_nettype none
`include "oscc_consts.svh"

// Notes on behaviour
// - divider low two bits in top register
// - odd divider ratios above one rounded up to even
// - divider code is ratio minus one
// - 38-bit word: top six bits, four bytes
// - soft reset resets logic, output clock off
// - soft reset bit self-clears when reset done
// - new-frequency bit self-clears once applied
// - word freeze keeps operating word unchanged
// - adc freeze holds tuning adc word
// - recall copies nvm, self-clears, zero ignored
// - recall leaves serial interface running
// - loop freeze bit four, rest reserved
// - control bits reset to zero
// - divider high five bits in preceding register
module oscc_regs
    import oscc_pkg::*;
(
    input  wire logic        I_SYS_CLK,
    input  wire logic        I_NRST,
    input  wire logic [7:0]  I_REG_ADDR,
    input  wire logic        I_REG_WR,
    input  wire logic [7:0]  I_REG_WDATA,
    input  wire logic        I_REG_RD,
    output logic      [7:0]  O_REG_RDATA,
    output logic             O_REG_RVALID,
    input  wire logic        I_NEW_FREQ_DONE,
    input  wire logic [7:0]  I_NVM_DATA,
    output logic      [2:0]  O_NVM_ADDR,
    output logic             O_SERIAL_ABORT,
    output logic             O_LOGIC_RST,
    output logic             O_OUTPUT_CLOCK_OE,
    output logic      [6:0]  O_OUTPUT_DIVIDER_ALT,
    output logic      [7:0]  O_OUT_DIV_RATIO,
    output logic      [37:0] O_REF_FREQ_WORD_ALT,
    output logic             O_NEW_FREQUENCY_APPLY,
    output logic             O_HOLD_TUNING_ADC_WORD,
    output logic             O_HOLD_OSCILLATOR_LOOP
);

    localparam int IMG_N     = `OSCC_IMG_BYTES;
    localparam int IDX_W     = `OSCC_IMG_IDX_W;
    localparam int CNT_W     = `OSCC_CNT_W;
    localparam int SRST_LAST = `OSCC_SOFT_RST_CYC - 1;
    localparam logic [CNT_W-1:0] SRST_CNT = CNT_W'(`OSCC_SOFT_RST_CYC);

    function automatic logic img_hit(input logic [7:0] a);
        return (a >= `OSCC_OFS_DIV_HI) && (a <= `OSCC_OFS_WORD_B1);
    endfunction : img_hit

    function automatic logic [IDX_W-1:0] img_index(input logic [7:0] a);
        logic [7:0] d;
        d = a - `OSCC_OFS_DIV_HI;
        return d[IDX_W-1:0];
    endfunction : img_index

    oscc_state_t        state_r;
    oscc_state_t        state_nxt;
    logic [CNT_W-1:0]   cnt_r;
    logic [CNT_W-1:0]   cnt_nxt;
    logic               abort_r;
    logic               abort_nxt;

    oscc_byte_t         img_r [IMG_N];
    oscc_byte_t         img_nxt [IMG_N];
    logic               newf_r;
    logic               newf_nxt;
    logic               hold_word_r;
    logic               hold_word_nxt;
    logic               hold_adc_r;
    logic               hold_adc_nxt;
    logic               hold_loop_r;
    logic               hold_loop_nxt;
    logic               recall_r;
    logic               recall_nxt;
    logic [37:0]        word_r;
    logic [37:0]        word_nxt;
    logic [6:0]         div_r;
    logic [6:0]         div_nxt;

    logic [7:0]         rdata_r;
    logic [7:0]         rdata_nxt;
    logic               rvalid_r;
    logic               rvalid_nxt;

    logic               in_srst;
    logic               wr_ok;
    logic               wr_ctrl;
    logic               wr_frz;
    logic               wr_img;
    logic               srst_req;
    logic               rcl_start;
    logic               rcl_load;
    logic [IDX_W-1:0]   rcl_idx;
    logic [7:0]         rcl_data;
    logic               rcl_done;

    // register writes are dropped while the soft reset runs
    assign in_srst  = (state_r == OSCC_SRST);
    assign wr_ok    = I_REG_WR && !in_srst;
    assign wr_ctrl  = wr_ok && (I_REG_ADDR == `OSCC_OFS_CTRL);
    assign wr_frz   = wr_ok && (I_REG_ADDR == `OSCC_OFS_FREEZE);
    assign wr_img   = wr_ok && img_hit(I_REG_ADDR);
    assign srst_req = wr_ctrl && I_REG_WDATA[`OSCC_BIT_SOFT_RST] && (state_r == OSCC_IDLE);

    // a recall starts on a host write of one, or after a soft reset
    assign rcl_start = ((state_r == OSCC_IDLE) && wr_ctrl && !srst_req
                        && I_REG_WDATA[`OSCC_BIT_RECALL])
                       || (in_srst && (cnt_r == CNT_W'(1)));

    oscc_recall #(
        .N_BYTES (IMG_N),
        .IDX_W   (IDX_W)
    ) u_recall (
        .i_clk       (I_SYS_CLK),
        .i_nrst      (I_NRST),
        .i_start     (rcl_start),
        .i_nvm_data  (I_NVM_DATA),
        .o_nvm_addr  (O_NVM_ADDR),
        .o_load      (rcl_load),
        .o_load_idx  (rcl_idx),
        .o_load_data (rcl_data),
        .o_done      (rcl_done)
    );

    oscc_div_decode #(
        .DIV_W (`OSCC_DIV_W)
    ) u_div (
        .i_clk   (I_SYS_CLK),
        .i_nrst  (I_NRST),
        .i_code  (div_r),
        .o_ratio (O_OUT_DIV_RATIO)
    );

    // sequencer: idle, soft reset countdown, recall copy
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        abort_nxt = 1'b0;
        case (state_r)
            OSCC_IDLE: begin
                if (srst_req) begin
                    state_nxt = OSCC_SRST;
                    cnt_nxt   = SRST_CNT;
                    abort_nxt = 1'b1;
                end else if (rcl_start) begin
                    state_nxt = OSCC_RCL;
                end
            end
            OSCC_SRST: begin
                if (cnt_r == CNT_W'(1)) begin
                    state_nxt = OSCC_RCL;
                end else begin
                    cnt_nxt = cnt_r - CNT_W'(1);
                end
            end
            OSCC_RCL: begin
                if (rcl_done) begin
                    state_nxt = OSCC_IDLE;
                end
            end
            default: begin
                state_nxt = OSCC_IDLE;
            end
        endcase
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_NRST) begin
            state_r <= OSCC_IDLE;
            cnt_r   <= '0;
            abort_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            abort_r <= abort_nxt;
        end
    end

    // register image, control bits and operating words
    always_comb begin
        for (int i = 0; i < IMG_N; i++) begin
            img_nxt[i] = img_r[i];
        end
        newf_nxt      = newf_r;
        hold_word_nxt = hold_word_r;
        hold_adc_nxt  = hold_adc_r;
        hold_loop_nxt = hold_loop_r;
        recall_nxt    = recall_r;
        word_nxt      = hold_word_r ? word_r
                        : {img_r[1][5:0], img_r[2], img_r[3], img_r[4], img_r[5]};
        div_nxt       = {img_r[0][4:0], img_r[1][7:6]};
        if (in_srst) begin
            for (int i = 0; i < IMG_N; i++) begin
                img_nxt[i] = `OSCC_RST_BYTE;
            end
            newf_nxt      = 1'b0;
            hold_word_nxt = 1'b0;
            hold_adc_nxt  = 1'b0;
            hold_loop_nxt = 1'b0;
            recall_nxt    = rcl_start;
            word_nxt      = `OSCC_RST_WORD;
            div_nxt       = `OSCC_RST_DIV;
        end else begin
            if (wr_img) begin
                img_nxt[img_index(I_REG_ADDR)] = I_REG_WDATA;
            end
            if (rcl_load) begin
                img_nxt[rcl_idx] = rcl_data;
            end
            if (wr_ctrl) begin
                hold_word_nxt = I_REG_WDATA[`OSCC_BIT_HOLD_WORD];
                hold_adc_nxt  = I_REG_WDATA[`OSCC_BIT_HOLD_ADC];
            end
            if (wr_frz) begin
                hold_loop_nxt = I_REG_WDATA[`OSCC_BIT_HOLD_LOOP];
            end
            if (I_NEW_FREQ_DONE) begin
                newf_nxt = 1'b0;
            end
            if (wr_ctrl && I_REG_WDATA[`OSCC_BIT_NEW_FREQ]) begin
                newf_nxt = 1'b1;
            end
            if (rcl_done) begin
                recall_nxt = 1'b0;
            end
            if (rcl_start) begin
                recall_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_NRST) begin
            for (int i = 0; i < IMG_N; i++) begin
                img_r[i] <= `OSCC_RST_BYTE;
            end
            newf_r      <= 1'b0;
            hold_word_r <= 1'b0;
            hold_adc_r  <= 1'b0;
            hold_loop_r <= 1'b0;
            recall_r    <= 1'b0;
            word_r      <= `OSCC_RST_WORD;
            div_r       <= `OSCC_RST_DIV;
        end else begin
            for (int i = 0; i < IMG_N; i++) begin
                img_r[i] <= img_nxt[i];
            end
            newf_r      <= newf_nxt;
            hold_word_r <= hold_word_nxt;
            hold_adc_r  <= hold_adc_nxt;
            hold_loop_r <= hold_loop_nxt;
            recall_r    <= recall_nxt;
            word_r      <= word_nxt;
            div_r       <= div_nxt;
        end
    end

    // read port: data one cycle after the strobe; unmapped reads zero
    always_comb begin
        rdata_nxt  = rdata_r;
        rvalid_nxt = I_REG_RD;
        if (I_REG_RD) begin
            if (img_hit(I_REG_ADDR)) begin
                rdata_nxt = img_r[img_index(I_REG_ADDR)];
            end else if (I_REG_ADDR == `OSCC_OFS_CTRL) begin
                rdata_nxt = {in_srst, newf_r, hold_word_r, hold_adc_r, 3'b000, recall_r};
            end else if (I_REG_ADDR == `OSCC_OFS_FREEZE) begin
                rdata_nxt = {3'b000, hold_loop_r, 4'h0};
            end else begin
                rdata_nxt = 8'h00;
            end
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_NRST) begin
            rdata_r  <= 8'h00;
            rvalid_r <= 1'b0;
        end else begin
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    assign O_REG_RDATA            = rdata_r;
    assign O_REG_RVALID           = rvalid_r;
    assign O_SERIAL_ABORT         = abort_r;
    assign O_LOGIC_RST            = in_srst;
    assign O_OUTPUT_CLOCK_OE      = !in_srst;
    assign O_OUTPUT_DIVIDER_ALT   = div_r;
    assign O_REF_FREQ_WORD_ALT    = word_r;
    assign O_NEW_FREQUENCY_APPLY  = newf_r;
    assign O_HOLD_TUNING_ADC_WORD = hold_adc_r;
    assign O_HOLD_OSCILLATOR_LOOP = hold_loop_r;

    default clocking cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (!I_NRST);

    property p_srst_tristate;
        srst_req |=> !O_OUTPUT_CLOCK_OE && O_LOGIC_RST;
    endproperty
    a_srst_tristate: assert property (p_srst_tristate) else $error("clock not off in reset");

    sequence s_srst_run;
        ##SRST_LAST O_LOGIC_RST ##1 !O_LOGIC_RST;
    endsequence

    property p_srst_selfclear;
        $rose(O_LOGIC_RST) |-> s_srst_run;
    endproperty
    a_srst_selfclear: assert property (p_srst_selfclear) else $error("soft reset length wrong");

    property p_newf_set;
        wr_ctrl && !srst_req && I_REG_WDATA[`OSCC_BIT_NEW_FREQ] |=> O_NEW_FREQUENCY_APPLY;
    endproperty
    a_newf_set: assert property (p_newf_set) else $error("new frequency bit lost");

    property p_newf_clear;
        O_NEW_FREQUENCY_APPLY && I_NEW_FREQ_DONE && !(wr_ctrl && I_REG_WDATA[6])
        |=> !O_NEW_FREQUENCY_APPLY;
    endproperty
    a_newf_clear: assert property (p_newf_clear) else $error("new frequency bit stuck");

    property p_word_hold;
        $past(hold_word_r) && !$past(in_srst) |-> $stable(O_REF_FREQ_WORD_ALT);
    endproperty
    a_word_hold: assert property (p_word_hold) else $error("frozen word changed");

    logic [37:0]        img_word;
    logic [6:0]         img_div;
    assign img_word = {img_r[1][5:0], img_r[2], img_r[3], img_r[4], img_r[5]};
    assign img_div  = {img_r[0][4:0], img_r[1][7:6]};

    property p_word_map;
        !hold_word_r && !in_srst |=> O_REF_FREQ_WORD_ALT == $past(img_word);
    endproperty
    a_word_map: assert property (p_word_map) else $error("word byte order wrong");

    property p_div_map;
        !in_srst |=> O_OUTPUT_DIVIDER_ALT == $past(img_div);
    endproperty
    a_div_map: assert property (p_div_map) else $error("divider field mapping wrong");

    property p_adc_hold;
        wr_ctrl && !srst_req |=> O_HOLD_TUNING_ADC_WORD == $past(I_REG_WDATA[4]);
    endproperty
    a_adc_hold: assert property (p_adc_hold) else $error("adc hold not written");

    property p_recall_zero;
        wr_ctrl && !I_REG_WDATA[0] && !recall_r && !srst_req |=> !recall_r;
    endproperty
    a_recall_zero: assert property (p_recall_zero) else $error("recall started on zero");

    property p_recall_clear;
        rcl_done |=> !recall_r;
    endproperty
    a_recall_clear: assert property (p_recall_clear) else $error("recall bit stuck");

    property p_recall_serial;
        recall_r |-> !O_SERIAL_ABORT;
    endproperty
    a_recall_serial: assert property (p_recall_serial) else $error("recall aborted serial");

    property p_loop_hold;
        wr_frz |=> O_HOLD_OSCILLATOR_LOOP == $past(I_REG_WDATA[4]);
    endproperty
    a_loop_hold: assert property (p_loop_hold) else $error("loop freeze not written");

    property p_reset_vals;
        !$past(I_NRST) |-> !O_NEW_FREQUENCY_APPLY && !recall_r && !O_LOGIC_RST;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("control bits not reset");

endmodule : oscc_regs

`default_nettype wire

// ### pkg/oscc_consts.svh
`ifndef OSCC_CONSTS_SVH
`define OSCC_CONSTS_SVH

// register offsets
`define OSCC_OFS_DIV_HI     8'h0d
`define OSCC_OFS_WORD_TOP   8'h0e
`define OSCC_OFS_WORD_B4    8'h0f
`define OSCC_OFS_WORD_B3    8'h10
`define OSCC_OFS_WORD_B2    8'h11
`define OSCC_OFS_WORD_B1    8'h12
`define OSCC_OFS_CTRL       8'h87
`define OSCC_OFS_FREEZE     8'h89

// control register fields
`define OSCC_BIT_SOFT_RST   7
`define OSCC_BIT_NEW_FREQ   6
`define OSCC_BIT_HOLD_WORD  5
`define OSCC_BIT_HOLD_ADC   4
`define OSCC_BIT_RECALL     0
// freeze register field
`define OSCC_BIT_HOLD_LOOP  4

// reset values
`define OSCC_RST_BYTE       8'h00
`define OSCC_RST_WORD       38'h00_0000_0000
`define OSCC_RST_DIV        7'h00

// field widths and image size
`define OSCC_DIV_W          7
`define OSCC_WORD_W         38
`define OSCC_IMG_BYTES      6
`define OSCC_IMG_IDX_W      3
`define OSCC_CNT_W          4

// timing
`define OSCC_CLK_PERIOD_NS  100
`define OSCC_SOFT_RST_NS    1000
`define OSCC_SOFT_RST_CYC   ((`OSCC_SOFT_RST_NS + `OSCC_CLK_PERIOD_NS - 1) / `OSCC_CLK_PERIOD_NS)

`endif

// ### pkg/oscc_pkg.sv
`default_nettype none

package oscc_pkg;

    typedef enum logic [2:0] {
        OSCC_IDLE = 3'b001,
        OSCC_SRST = 3'b010,
        OSCC_RCL  = 3'b100
    } oscc_state_t;

    typedef logic [7:0] oscc_byte_t;

endpackage : oscc_pkg

`default_nettype wire

// ### hdl/oscc_div_decode.sv
`timescale 1ns/100ps
`default_nettype none
`include "oscc_consts.svh"

module oscc_div_decode
    import oscc_pkg::*;
#(
    parameter int DIV_W = `OSCC_DIV_W
) (
    input  wire logic             i_clk,
    input  wire logic             i_nrst,
    input  wire logic [DIV_W-1:0] i_code,
    output logic      [DIV_W:0]   o_ratio
);

    logic [DIV_W:0] ratio_r;
    logic [DIV_W:0] ratio_nxt;

    // code is ratio minus one; odd ratios above one round up to even
    always_comb begin
        ratio_nxt = {1'b0, i_code} + (DIV_W+1)'(1);
        if ((i_code != '0) && ratio_nxt[0]) begin
            ratio_nxt = ratio_nxt + (DIV_W+1)'(1);
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            ratio_r <= (DIV_W+1)'(1);
        end else begin
            ratio_r <= ratio_nxt;
        end
    end

    assign o_ratio = ratio_r;

    property p_div_even;
        @(posedge i_clk) disable iff (!i_nrst)
        (i_code != '0) |=> (o_ratio[0] == 1'b0) && (o_ratio >= {1'b0, $past(i_code)});
    endproperty
    a_div_even: assert property (p_div_even) else $error("odd ratio not rounded up");

    property p_div_code;
        @(posedge i_clk) disable iff (!i_nrst)
        (i_code == 7'h00 |=> o_ratio == 8'h01) and (i_code == 7'h09 |=> o_ratio == 8'h0a)
        and (i_code == 7'h7f |=> o_ratio == 8'h80);
    endproperty
    a_div_code: assert property (p_div_code) else $error("divider code decode wrong");

endmodule : oscc_div_decode

`default_nettype wire

// ### hdl/oscc_recall.sv
`timescale 1ns/100ps
`default_nettype none
`include "oscc_consts.svh"

module oscc_recall
    import oscc_pkg::*;
#(
    parameter int N_BYTES = `OSCC_IMG_BYTES,
    parameter int IDX_W   = `OSCC_IMG_IDX_W
) (
    input  wire logic             i_clk,
    input  wire logic             i_nrst,
    input  wire logic             i_start,
    input  wire logic [7:0]       i_nvm_data,
    output logic      [IDX_W-1:0] o_nvm_addr,
    output logic                  o_load,
    output logic      [IDX_W-1:0] o_load_idx,
    output logic      [7:0]       o_load_data,
    output logic                  o_done
);

    localparam logic [IDX_W-1:0] LAST = IDX_W'(N_BYTES - 1);

    logic             busy_r;
    logic             busy_nxt;
    logic [IDX_W-1:0] addr_r;
    logic [IDX_W-1:0] addr_nxt;
    logic             load_r;
    logic             load_nxt;
    logic [IDX_W-1:0] idx_r;
    logic [IDX_W-1:0] idx_nxt;
    logic [7:0]       data_r;
    logic [7:0]       data_nxt;
    logic             done_r;
    logic             done_nxt;

    // walks the nvm image one byte per cycle; nvm read is combinational
    always_comb begin
        busy_nxt = busy_r;
        addr_nxt = addr_r;
        load_nxt = 1'b0;
        idx_nxt  = idx_r;
        data_nxt = data_r;
        done_nxt = 1'b0;
        if (busy_r) begin
            load_nxt = 1'b1;
            idx_nxt  = addr_r;
            data_nxt = i_nvm_data;
            if (addr_r == LAST) begin
                busy_nxt = 1'b0;
                done_nxt = 1'b1;
            end else begin
                addr_nxt = addr_r + IDX_W'(1);
            end
        end else if (i_start) begin
            busy_nxt = 1'b1;
            addr_nxt = '0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            busy_r <= 1'b0;
            addr_r <= '0;
            load_r <= 1'b0;
            idx_r  <= '0;
            data_r <= 8'h00;
            done_r <= 1'b0;
        end else begin
            busy_r <= busy_nxt;
            addr_r <= addr_nxt;
            load_r <= load_nxt;
            idx_r  <= idx_nxt;
            data_r <= data_nxt;
            done_r <= done_nxt;
        end
    end

    assign o_nvm_addr  = addr_r;
    assign o_load      = load_r;
    assign o_load_idx  = idx_r;
    assign o_load_data = data_r;
    assign o_done      = done_r;

    sequence s_copy_start;
        i_start && !busy_r;
    endsequence

    sequence s_copy_walk;
        (o_load && !o_done)[*5] ##1 (o_load && o_done && o_load_idx == 3'h5);
    endsequence

    property p_copy_walk;
        @(posedge i_clk) disable iff (!i_nrst)
        s_copy_start |=> ##1 s_copy_walk;
    endproperty
    a_copy_walk: assert property (p_copy_walk) else $error("recall copy walk broken");

endmodule : oscc_recall

`default_nettype wire

// ### test/oscc_far_model.sv
`timescale 1ns/100ps
`default_nettype none

module oscc_far_model #(
    parameter int DONE_DLY = 3
) (
    input  wire logic       i_clk,
    input  wire logic       i_nrst,
    input  wire logic [2:0] i_nvm_addr,
    input  wire logic       i_apply,
    output logic      [7:0] o_nvm_data,
    output logic            o_done
);
    logic [3:0] cnt_r;

    // nvm image, read without delay; outside the image a changing pattern
    always_comb begin
        case (i_nvm_addr)
            3'h0: o_nvm_data = 8'h03;
            3'h1: o_nvm_data = 8'hc5;
            3'h2: o_nvm_data = 8'h12;
            3'h3: o_nvm_data = 8'h34;
            3'h4: o_nvm_data = 8'h56;
            3'h5: o_nvm_data = 8'h78;
            default: o_nvm_data = {cnt_r, 1'b1, i_nvm_addr};
        endcase
    end

    // synthesis loop reports the new frequency applied after a delay
    always_ff @(posedge i_clk) begin
        if (!i_nrst || !i_apply || o_done) begin
            cnt_r  <= 4'h0;
            o_done <= 1'b0;
        end else begin
            cnt_r  <= cnt_r + 4'h1;
            o_done <= (cnt_r == 4'(DONE_DLY));
        end
    end
endmodule : oscc_far_model

`default_nettype wire

// ### test/oscc_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "oscc_consts.svh"

module oscc_regs_tb;
    logic        I_SYS_CLK = 1'b0;
    logic        I_NRST    = 1'b0;
    logic [7:0]  addr      = 8'h00;
    logic        wr        = 1'b0;
    logic [7:0]  wdata     = 8'h00;
    logic        rd        = 1'b0;
    logic [7:0]  rdata, nvm_data, ratio;
    logic        rvalid, done, abort, lrst, oe, apply, hadc, hloop;
    logic [2:0]  nvm_addr;
    logic [6:0]  divc;
    logic [37:0] word;
    int          failures = 0;
    int          compares = 0;
    int          cyc = 0;
    logic [14:0] rows [5] = '{{7'h00, 8'h01}, {7'h09, 8'h0a}, {7'h7f, 8'h80},
                              {7'h02, 8'h04}, {7'h01, 8'h02}};

    always #50 I_SYS_CLK = ~I_SYS_CLK;

    oscc_regs u_oscc_regs (.I_SYS_CLK(I_SYS_CLK), .I_NRST(I_NRST), .I_REG_ADDR(addr),
        .I_REG_WR(wr), .I_REG_WDATA(wdata), .I_REG_RD(rd), .O_REG_RDATA(rdata),
        .O_REG_RVALID(rvalid), .I_NEW_FREQ_DONE(done), .I_NVM_DATA(nvm_data),
        .O_NVM_ADDR(nvm_addr), .O_SERIAL_ABORT(abort), .O_LOGIC_RST(lrst),
        .O_OUTPUT_CLOCK_OE(oe), .O_OUTPUT_DIVIDER_ALT(divc), .O_OUT_DIV_RATIO(ratio),
        .O_REF_FREQ_WORD_ALT(word), .O_NEW_FREQUENCY_APPLY(apply),
        .O_HOLD_TUNING_ADC_WORD(hadc), .O_HOLD_OSCILLATOR_LOOP(hloop));

    oscc_far_model u_oscc_far_model (.i_clk(I_SYS_CLK), .i_nrst(I_NRST),
        .i_nvm_addr(nvm_addr), .i_apply(apply), .o_nvm_data(nvm_data), .o_done(done));

    task automatic chk(input string nm, input logic [37:0] exp, input logic [37:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge I_SYS_CLK);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge I_SYS_CLK);
        wr    <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge I_SYS_CLK);
        addr <= a;
        rd   <= 1'b1;
        @(posedge I_SYS_CLK);
        rd   <= 1'b0;
        #1;
        chk("rvalid", 38'h1, 38'(rvalid));
        chk("rdata", 38'(exp), 38'(rdata));
    endtask : rd_reg

    task automatic idle(input int n);
        repeat (n) @(posedge I_SYS_CLK);
        #1;
    endtask : idle

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up

    always @(posedge I_SYS_CLK) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            failures++;
            wrap_up();
        end
    end

    initial begin
        repeat (4) @(posedge I_SYS_CLK);
        I_NRST <= 1'b1;
        idle(1);
        chk("oe after reset", 38'h1, 38'(oe));
        chk("ratio after reset", 38'h1, 38'(ratio));
        chk("apply after reset", 38'h0, 38'(apply));
        rd_reg(`OSCC_OFS_CTRL, 8'h00);
        rd_reg(8'h40, 8'h00);
        $display("test reset done");
        // divider code split over two registers, odd ratios above one rounded to even
        foreach (rows[i]) begin
            wr_reg(`OSCC_OFS_DIV_HI, {3'h0, rows[i][14:10]});
            wr_reg(`OSCC_OFS_WORD_TOP, {rows[i][9:8], 6'h00});
            idle(3);
            chk("div code", 38'(rows[i][14:8]), 38'(divc));
            chk("div ratio", 38'(rows[i][7:0]), 38'(ratio));
        end
        $display("test divider done");
        wr_reg(`OSCC_OFS_FREEZE, 8'hff);
        rd_reg(`OSCC_OFS_FREEZE, 8'h10);
        chk("loop hold", 38'h1, 38'(hloop));
        wr_reg(`OSCC_OFS_WORD_TOP, 8'h2a);
        wr_reg(`OSCC_OFS_WORD_B4, 8'h81);
        wr_reg(`OSCC_OFS_WORD_B3, 8'h42);
        wr_reg(`OSCC_OFS_WORD_B2, 8'h24);
        wr_reg(`OSCC_OFS_WORD_B1, 8'h18);
        idle(2);
        chk("word", 38'h2a_8142_2418, word);
        rd_reg(`OSCC_OFS_WORD_B3, 8'h42);
        wr_reg(`OSCC_OFS_CTRL, 8'h3e);
        rd_reg(`OSCC_OFS_CTRL, 8'h30);
        chk("adc hold", 38'h1, 38'(hadc));
        wr_reg(`OSCC_OFS_WORD_B1, 8'hee);
        idle(3);
        chk("word frozen", 38'h2a_8142_2418, word);
        wr_reg(`OSCC_OFS_CTRL, 8'h00);
        idle(3);
        chk("word released", 38'h2a_8142_24ee, word);
        wr_reg(`OSCC_OFS_FREEZE, 8'h00);
        wr_reg(`OSCC_OFS_CTRL, 8'h40);
        idle(1);
        chk("apply set", 38'h1, 38'(apply));
        idle(8);
        chk("apply cleared", 38'h0, 38'(apply));
        $display("test word done");
        wr_reg(`OSCC_OFS_CTRL, 8'h01);
        rd_reg(`OSCC_OFS_CTRL, 8'h01);
        rd_reg(`OSCC_OFS_WORD_B2, 8'h24);
        idle(8);
        rd_reg(`OSCC_OFS_CTRL, 8'h00);
        chk("recall word", 38'h05_1234_5678, word);
        chk("recall div", 38'h0f, 38'(divc));
        chk("no abort", 38'h0, 38'(abort));
        wr_reg(`OSCC_OFS_WORD_B1, 8'h99);
        wr_reg(`OSCC_OFS_CTRL, 8'h00);
        idle(10);
        rd_reg(`OSCC_OFS_WORD_B1, 8'h99);
        $display("test recall done");
        wr_reg(`OSCC_OFS_CTRL, 8'h80);
        #1;
        chk("abort", 38'h1, 38'(abort));
        chk("logic reset", 38'h1, 38'(lrst));
        chk("oe off", 38'h0, 38'(oe));
        idle(8);
        chk("oe still off", 38'h0, 38'(oe));
        idle(12);
        chk("logic reset over", 38'h0, 38'(lrst));
        chk("oe back", 38'h1, 38'(oe));
        rd_reg(`OSCC_OFS_CTRL, 8'h00);
        chk("word reloaded", 38'h05_1234_5678, word);
        $display("test soft reset done");
        wrap_up();
    end
endmodule : oscc_regs_tb

`default_nettype wire
